// >>> srbg_top.sv
/*
 * Serial rate generator: prescaler, 8/16-bit reloading rate timer, divisor
 * holding registers and receive-pin majority sampling.
 *
 * Prescale P follows the mode: asynchronous narrow normal speed 64,
 * asynchronous narrow high speed or wide normal speed 16, asynchronous wide
 * high speed 4, and 4 in every synchronous setting.
 * The effective divisor N is the low byte alone in narrow mode and the
 * high:low pair in wide mode; the high byte is kept while unused.
 * The prescaler counts P-1 down to zero and then strobes once; the rate
 * timer steps N down to zero, one step per strobe, and ticks on the strobe
 * that finds it at zero, reloading N at the same time.
 * Ticks therefore repeat every P*(N+1) enabled cycles and last one cycle.
 * The tick and the strobe are both registered and rise on the same edge.
 * A write to either divisor byte reloads both counters in the cycle it is
 * taken, so the first period after it is a full one on the new value;
 * reloading rather than zeroing gives up an early tick for an exact period.
 * Writing both bytes in one cycle stores the same data byte in both.
 * A mode or divisor change that leaves a counter above its new limit counts
 * as a wrap, so the new rate starts without a long stale count.
 * A synchronous slave keeps both counters running but never ticks, since
 * its bit clock comes from outside.
 * The receive pin passes two flip-flops, then one sample is shifted into
 * the voter on each prescaler strobe; three samples span 2*P cycles and the
 * level follows two of the three.
 * The clock enable freezes every register, the voter's included; a divisor
 * write made while it is low is lost, not held over.
 * Out of reset: divisor zero, rate timer zero, prescaler at its largest
 * preset, tick low and receive level high, as on an idle line.
 *
 * Assumes software writes divisor bytes through strobes on this clock and
 * that every other control input also comes from logic on this clock; the
 * receive pin is asynchronous and is synchronised here.
 */
`timescale 1ns/100ps
`include "srbg_cfg.svh"

module srbg_top (
    input  wire logic          clock_in,
    input  wire logic          resetn_in,
    input  wire logic          enable_in,
    input  wire logic          sync_mode_in,
    input  wire logic          master_mode_in,
    input  wire logic          wide_divider_select_in,
    input  wire logic          high_speed_select_in,
    input  wire logic [7:0]    divisor_data_in,
    input  wire logic          divisor_low_wr_in,
    input  wire logic          divisor_high_wr_in,
    input  wire logic          rx_pin_in,
    output logic               rate_tick_out,
    output logic               rx_level_out,
    output logic [15:0]        divisor_value_out,
    output logic [15:0]        rate_count_out
);

    srbg_pkg::srbg_top_state_type state_reg;
    srbg_pkg::srbg_top_state_type state_next;

    srbg_vote_if vote_if ();

    logic [2:0]             mode_sel;
    logic [`SRBG_PRE_W-1:0] pre_preset;
    logic [15:0]            divisor;
    logic                   generating;
    logic                   div_write;
    logic [7:0]             new_low;
    logic [7:0]             new_high;
    logic                   pre_zero;
    logic                   pre_over;
    logic                   pre_wrap;
    logic [`SRBG_PRE_W-1:0] pre_dec;
    logic                   rate_zero;
    logic                   rate_over;
    logic                   rate_wrap;
    logic [15:0]            rate_dec;
    logic                   load_pre;
    logic                   load_rate;
    logic                   count_rate;
    logic                   strobe_next;
    logic                   tick_next;

    // configuration bits as sync, wide divider, high speed
    always_comb begin
        mode_sel = {sync_mode_in, wide_divider_select_in, high_speed_select_in};
    end

    // prescale selection by mode, held as prescale minus one
    always_comb begin
        case (mode_sel)
            3'b000:  pre_preset = `SRBG_PRE_DIV64;
            3'b001:  pre_preset = `SRBG_PRE_DIV16;
            3'b010:  pre_preset = `SRBG_PRE_DIV16;
            3'b011:  pre_preset = `SRBG_PRE_DIV4;
            // synchronous: high speed select has no effect
            3'b100:  pre_preset = `SRBG_PRE_DIV4;
            3'b101:  pre_preset = `SRBG_PRE_DIV4;
            3'b110:  pre_preset = `SRBG_PRE_DIV4;
            3'b111:  pre_preset = `SRBG_PRE_DIV4;
            default: pre_preset = `SRBG_PRE_DIV64;
        endcase
    end

    // a strobe replaces its byte, the other byte is kept
    always_comb begin
        div_write = divisor_low_wr_in | divisor_high_wr_in;
        if (divisor_low_wr_in) begin
            new_low = divisor_data_in;
        end else begin
            new_low = state_reg.div_low;
        end
        if (divisor_high_wr_in) begin
            new_high = divisor_data_in;
        end else begin
            new_high = state_reg.div_high;
        end
    end

    // narrow mode leaves the high byte out of the divisor, though a high-byte write still reloads both counters
    always_comb begin
        if (wide_divider_select_in) begin
            divisor = {new_high, new_low};
        end else begin
            divisor = {`SRBG_BYTE_RST, new_low};
        end
    end

    // a synchronous slave is clocked from outside
    always_comb begin
        generating = master_mode_in | ~sync_mode_in;
    end

    // overrun catches a mode change to a shorter prescale
    always_comb begin
        pre_zero = (state_reg.pre_cnt == `SRBG_PRE_ZERO);
        pre_over = (state_reg.pre_cnt > pre_preset);
        pre_wrap = pre_zero | pre_over;
        pre_dec  = state_reg.pre_cnt - `SRBG_PRE_W'(1);
    end

    // overrun catches a divisor that shrank under the count
    always_comb begin
        rate_zero = (state_reg.rate_cnt == `SRBG_CNT_RST);
        rate_over = (state_reg.rate_cnt > divisor);
        rate_wrap = rate_zero | rate_over;
        rate_dec  = state_reg.rate_cnt - `SRBG_CNT_ONE;
    end

    // restart on the new value rather than finishing the old period
    always_comb begin
        load_pre    = div_write | pre_wrap;
        strobe_next = ~div_write & pre_wrap;
        load_rate   = div_write | (pre_wrap & rate_wrap);
        count_rate  = ~div_write & pre_wrap & ~rate_wrap;
        tick_next   = strobe_next & rate_wrap & generating;
    end

    always_comb begin
        state_next          = state_reg;
        state_next.rx_meta  = rx_pin_in;
        state_next.rx_sync  = state_reg.rx_meta;
        state_next.div_low  = new_low;
        state_next.div_high = new_high;
        state_next.strobe   = strobe_next;
        state_next.tick     = tick_next;
        if (load_pre) begin
            state_next.pre_cnt = pre_preset;
        end else begin
            state_next.pre_cnt = pre_dec;
        end
        if (load_rate) begin
            state_next.rate_cnt = divisor;
        end else if (count_rate) begin
            state_next.rate_cnt = rate_dec;
        end
    end

    // idle receive line is high, so the synchroniser starts high
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= '{rx_meta:  1'b1,
                           rx_sync:  1'b1,
                           div_low:  `SRBG_BYTE_RST,
                           div_high: `SRBG_BYTE_RST,
                           pre_cnt:  `SRBG_PRE_DIV64,
                           rate_cnt: `SRBG_CNT_RST,
                           strobe:   1'b0,
                           tick:     1'b0};
        end else if (enable_in) begin
            state_reg <= state_next;
        end
    end

    assign vote_if.enable        = enable_in;
    assign vote_if.sample_strobe = state_reg.strobe;
    assign vote_if.pin_level     = state_reg.rx_sync;

    // voter state freezes with the rest under the clock enable
    srbg_vote u_vote (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .vote_if   (vote_if)
    );

    assign rate_tick_out     = state_reg.tick;
    assign rx_level_out      = vote_if.bit_level;
    assign divisor_value_out = {state_reg.div_high, state_reg.div_low};
    assign rate_count_out    = state_reg.rate_cnt;

endmodule : srbg_top

// >>> srbg_cfg.svh
/*
 * Constants for the serial rate generator: prescale presets, reset values, widths.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SRBG_CFG_SVH
`define SRBG_CFG_SVH

`define SRBG_PRE_W          6
// presets are prescale minus one
`define SRBG_PRE_DIV64      6'h3F
`define SRBG_PRE_DIV16      6'h0F
`define SRBG_PRE_DIV4       6'h03
`define SRBG_PRE_ZERO       6'h00
`define SRBG_BYTE_RST       8'h00
`define SRBG_CNT_RST        16'h0000
`define SRBG_CNT_ONE        16'h0001
`define SRBG_VOTE_N         3
`define SRBG_VOTE_RST       3'h7

`endif

// >>> srbg_pkg.sv
/*
 * Types shared by the rate generator top and its receive voter.
 * Assumes srbg_cfg.svh is on the include path.
 */
`include "srbg_cfg.svh"

package srbg_pkg;

    typedef struct packed {
        logic                      rx_meta;
        logic                      rx_sync;
        logic [7:0]                div_low;
        logic [7:0]                div_high;
        logic [`SRBG_PRE_W-1:0]    pre_cnt;
        logic [15:0]               rate_cnt;
        logic                      strobe;
        logic                      tick;
    } srbg_top_state_type;

    typedef struct packed {
        logic [`SRBG_VOTE_N-1:0]   samples;
        logic                      bit_level;
    } srbg_vote_state_type;

endpackage : srbg_pkg

// >>> srbg_vote_if.sv
/*
 * Carrier between the rate generator top and the majority voter.
 * Assumes both ends share clock_in and resetn_in.
 */
`timescale 1ns/100ps

interface srbg_vote_if;
    logic enable;
    logic sample_strobe;
    logic pin_level;
    logic bit_level;

    modport gen   (output enable, output sample_strobe, output pin_level, input bit_level);
    modport voter (input enable, input sample_strobe, input pin_level, output bit_level);
endinterface : srbg_vote_if

// >>> srbg_vote.sv
/*
 * Majority voter for the receive pin: keeps the last three samples.
 * Assumes the pin level is already synchronised and strobes come from the prescaler.
 */
`timescale 1ns/100ps
`include "srbg_cfg.svh"

module srbg_vote (
    input  wire logic    clock_in,
    input  wire logic    resetn_in,
    srbg_vote_if.voter   vote_if
);

    srbg_pkg::srbg_vote_state_type state_reg;
    srbg_pkg::srbg_vote_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (vote_if.sample_strobe) begin
            state_next.samples = {state_reg.samples[`SRBG_VOTE_N-2:0], vote_if.pin_level};
            state_next.bit_level = (state_next.samples[0] & state_next.samples[1]) |
                                   (state_next.samples[1] & state_next.samples[2]) |
                                   (state_next.samples[0] & state_next.samples[2]);
        end
    end

    // idle line is high, so history starts at all ones
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= '{samples: `SRBG_VOTE_RST, bit_level: 1'b1};
        end else if (vote_if.enable) begin
            state_reg <= state_next;
        end
    end

    assign vote_if.bit_level = state_reg.bit_level;

endmodule : srbg_vote

// >>> srbg_props.sv
/* port checker for srbg_top
   assumes a bind from the bench and one clock domain */
`timescale 1ns/100ps
module srbg_props (
    input wire logic        clock_in,
    input wire logic        resetn_in,
    input wire logic        enable_in,
    input wire logic        sync_mode_in,
    input wire logic        master_mode_in,
    input wire logic        wide_divider_select_in,
    input wire logic        high_speed_select_in,
    input wire logic [7:0]  divisor_data_in,
    input wire logic        divisor_low_wr_in,
    input wire logic        divisor_high_wr_in,
    input wire logic        rx_pin_in,
    input wire logic        rate_tick_out,
    input wire logic        rx_level_out,
    input wire logic [15:0] divisor_value_out,
    input wire logic [15:0] rate_count_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    logic wr;
    assign wr = enable_in && (divisor_low_wr_in || divisor_high_wr_in);
    property p_wr_low;
        enable_in && divisor_low_wr_in |=> divisor_value_out[7:0] == $past(divisor_data_in);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("low byte lost");
    property p_wr_high;
        enable_in && divisor_high_wr_in |=> divisor_value_out[15:8] == $past(divisor_data_in);
    endproperty
    a_wr_high: assert property (p_wr_high) else $error("high byte lost");
    property p_restart;
        wr |=> rate_count_out == (wide_divider_select_in ? divisor_value_out : {8'h00, divisor_value_out[7:0]});
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on write");
    property p_hold_div;
        !wr |=> $stable(divisor_value_out);
    endproperty
    a_hold_div: assert property (p_hold_div) else $error("divisor changed");
    property p_slave;
        sync_mode_in && !master_mode_in && $past(sync_mode_in && !master_mode_in) |-> !rate_tick_out;
    endproperty
    a_slave: assert property (p_slave) else $error("tick in slave mode");
    property p_pulse;
        rate_tick_out && enable_in |=> !rate_tick_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("tick too long");
    property p_freeze;
        !enable_in |=> $stable(rate_count_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("timer ran while stopped");
    property p_sync_per;
        rate_tick_out && enable_in && sync_mode_in && master_mode_in && !wide_divider_select_in
            && divisor_value_out[7:0] == 8'h00 |=> !rate_tick_out [*3] ##1 rate_tick_out;
    endproperty
    a_sync_per: assert property (p_sync_per) else $error("sync period not 4");
    c_async: cover property (rate_tick_out && !sync_mode_in);
    c_slave: cover property (sync_mode_in && !master_mode_in && wr);
    c_rx: cover property ($fell(rx_level_out));
endmodule : srbg_props

// >>> tb.sv
/* self-checking bench for srbg_top, stimulus on the falling edge
   assumes the design files and srbg_props.sv compiled first */
`timescale 1ns/100ps
module tb;
    logic        clock_in, resetn_in, enable_in, sync_mode_in, master_mode_in, rx_pin_in;
    logic        wide_divider_select_in, high_speed_select_in, divisor_low_wr_in, divisor_high_wr_in;
    logic [7:0]  divisor_data_in;
    logic        rate_tick_out, rx_level_out;
    logic [15:0] divisor_value_out, rate_count_out, c0;
    int          n_mismatch = 0, checks = 0, k;
    logic [2:0]  mode [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    logic [15:0] per [6] = '{16'h00C0, 16'h0030, 16'h1030, 16'h040C, 16'h000C, 16'h040C};
    srbg_top srbg_top_i (.clock_in(clock_in), .resetn_in(resetn_in), .enable_in(enable_in),
        .sync_mode_in(sync_mode_in), .master_mode_in(master_mode_in), .rx_pin_in(rx_pin_in),
        .wide_divider_select_in(wide_divider_select_in), .high_speed_select_in(high_speed_select_in),
        .divisor_data_in(divisor_data_in), .divisor_low_wr_in(divisor_low_wr_in),
        .divisor_high_wr_in(divisor_high_wr_in), .rate_tick_out(rate_tick_out), .rx_level_out(rx_level_out),
        .divisor_value_out(divisor_value_out), .rate_count_out(rate_count_out));
    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic hi, input logic [7:0] d);
        divisor_data_in = d;
        {divisor_high_wr_in, divisor_low_wr_in} = {hi, !hi};
        @(negedge clock_in);
        {divisor_high_wr_in, divisor_low_wr_in} = 2'h0;
        // idle cycle so a following write never reassigns a strobe in the same step
        @(negedge clock_in);
    endtask : wr
    // bounded wait for the next tick; c gives the gap in cycles
    task wait_tick(output int c);
        c = 0;
        do begin
            @(negedge clock_in);
            c++;
            if (c > 9000) begin
                n_mismatch++;
                close_out();
            end
        end while (rate_tick_out !== 1'b1);
    endtask : wait_tick
    task period(input logic [15:0] e);
        int c;
        wait_tick(c);
        wait_tick(c);
        chk("period", e, c[15:0]);
    endtask : period
    initial begin
        clock_in = 0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial begin
        {resetn_in, enable_in, master_mode_in, rx_pin_in, divisor_data_in} = 12'h700;
        {sync_mode_in, wide_divider_select_in, high_speed_select_in, divisor_low_wr_in, divisor_high_wr_in} = 5'h00;
        repeat (3) @(negedge clock_in);
        chk("reset state", 16'h0001, {divisor_value_out[13:0] | rate_count_out[13:0], rate_tick_out, rx_level_out});
        resetn_in = 1;
        for (int i = 0; i < 6; i++) begin
            {sync_mode_in, wide_divider_select_in, high_speed_select_in} = mode[i];
            wr(1, 8'h01);
            wr(0, 8'h02);
            period(per[i]);
        end
        chk("divisor", 16'h0102, divisor_value_out);
        enable_in = 0;
        c0 = rate_count_out;
        wr(0, 8'h07);
        repeat (5) @(negedge clock_in);
        chk("frozen count", c0, rate_count_out);
        chk("ignored write", 16'h0102, divisor_value_out);
        {enable_in, sync_mode_in, master_mode_in, wide_divider_select_in} = 4'hC;
        wr(0, 8'h00);
        k = 0;
        repeat (40) @(negedge clock_in) k += int'(rate_tick_out === 1'b1);
        chk("slave ticks", 16'h0000, 16'(k));
        master_mode_in = 1;
        period(16'h0004);
        rx_pin_in = 0;
        repeat (30) @(negedge clock_in);
        chk("rx low", 16'h0000, 16'(rx_level_out));
        rx_pin_in = 1;
        repeat (3) @(negedge clock_in);
        rx_pin_in = 0;
        k = 0;
        repeat (30) @(negedge clock_in) k += int'(rx_level_out !== 1'b0);
        chk("rx single sample", 16'h0000, 16'(k));
        rx_pin_in = 1;
        repeat (30) @(negedge clock_in);
        chk("rx high", 16'h0001, 16'(rx_level_out));
        close_out();
    end
endmodule : tb
bind srbg_top srbg_props srbg_props_i (.clock_in(clock_in), .resetn_in(resetn_in), .enable_in(enable_in),
    .sync_mode_in(sync_mode_in), .master_mode_in(master_mode_in), .rx_pin_in(rx_pin_in),
    .wide_divider_select_in(wide_divider_select_in), .high_speed_select_in(high_speed_select_in),
    .divisor_data_in(divisor_data_in), .divisor_low_wr_in(divisor_low_wr_in),
    .divisor_high_wr_in(divisor_high_wr_in), .rate_tick_out(rate_tick_out), .rx_level_out(rx_level_out),
    .divisor_value_out(divisor_value_out), .rate_count_out(rate_count_out));
